// [rtl/iasc_pkg.sv]
package iasc_pkg;

   localparam int unsigned DATA_W = 32;

   // Register byte offsets on the bus.
   localparam logic [7:0] OFF_OPND1  = 8'h00;
   localparam logic [7:0] OFF_SRC    = 8'h04;
   localparam logic [7:0] OFF_SHAMT  = 8'h08;
   localparam logic [7:0] OFF_PC     = 8'h0C;
   localparam logic [7:0] OFF_CTRL   = 8'h10;
   localparam logic [7:0] OFF_RESULT = 8'h14;
   localparam logic [7:0] OFF_FLAGS  = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;

   // Control word fields.
   localparam int unsigned CTRL_OP_LSB    = 0;
   localparam int unsigned CTRL_OP_W      = 5;
   localparam int unsigned CTRL_SETF_BIT  = 5;
   localparam int unsigned CTRL_IMM_BIT   = 6;
   localparam int unsigned CTRL_PC_BIT    = 7;
   localparam int unsigned CTRL_NODST_BIT = 8;
   localparam int unsigned CTRL_SHIMM_BIT = 9;
   localparam int unsigned CTRL_SHN_LSB   = 10;
   localparam int unsigned CTRL_SHN_W     = 6;
   localparam int unsigned CTRL_IMM_LSB   = 16;
   localparam int unsigned IMM_FIELD_W    = 12;

   // Flag and status bit positions.
   localparam int unsigned FLAG_N = 3;
   localparam int unsigned FLAG_Z = 2;
   localparam int unsigned FLAG_C = 1;
   localparam int unsigned FLAG_V = 0;
   localparam int unsigned STAT_ILLEGAL_BIT = 0;
   localparam int unsigned STAT_BRANCH_BIT  = 1;

   // Reset values.
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [3:0]  RST_FLAGS = 4'h0;

   // Immediate shift count limits and shifter saturation.
   localparam logic [5:0] SH_IMM_MIN       = 6'h01;
   localparam logic [5:0] SH_IMM_MAX_SHL   = 6'h1F;
   localparam logic [5:0] SH_IMM_MAX_RIGHT = 6'h20;
   localparam logic [5:0] SH_IMM_MAX_ROT   = 6'h1F;
   localparam logic [7:0] SH_SAT           = 8'h21;
   localparam logic [5:0] LZC_ALL_ZERO     = 6'h20;

   typedef enum logic [4:0] {
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CARRY, OP_REV_SUB,
      OP_AND, OP_OR, OP_XOR, OP_BIT_CLEAR, OP_OR_NOT,
      OP_ASHR, OP_SHL, OP_SHR, OP_ROT, OP_ROT_EXT,
      OP_LZC, OP_ADD_PC_BRANCH
   } iasc_op_t;

   localparam logic [4:0] OP_COUNT = 5'h11;

   typedef enum logic [2:0] {
      SHK_SHL, SHK_SHR, SHK_ASHR, SHK_ROT, SHK_ROT_EXT
   } iasc_shk_t;

endpackage

// [rtl/iasc_shifter.sv]
`timescale 1ns/1ps
module iasc_shifter (
   input  wire logic [31:0]         val,
   input  wire logic [7:0]          amt,
   input  iasc_pkg::iasc_shk_t      kind,
   input  wire logic                cin,
   output logic      [31:0]         res,
   output logic                     cout
);
   logic [7:0]  sat;
   logic        fill;
   logic [64:0] left_w;
   logic [65:0] right_w;
   logic [63:0] rot_w;

   // Left and right shift counts above 33 behave like 33, which keeps the wide shifts small.
   always_comb begin
      sat     = (amt > iasc_pkg::SH_SAT) ? iasc_pkg::SH_SAT : amt;
      fill    = (kind == iasc_pkg::SHK_ASHR) & val[31];
      left_w  = {33'h0_0000_0000, val} << sat;
      right_w = {{33{fill}}, val, 1'b0} >> sat;
      rot_w   = {val, val} >> amt[4:0];
      res     = val;
      cout    = cin;
      unique case (kind)
         iasc_pkg::SHK_SHL: begin
            if (amt != 8'h00) begin
               res  = left_w[31:0];
               cout = left_w[32];
            end
         end
         iasc_pkg::SHK_SHR, iasc_pkg::SHK_ASHR: begin
            if (amt != 8'h00) begin
               res  = right_w[32:1];
               cout = right_w[0];
            end
         end
         iasc_pkg::SHK_ROT: begin
            if (amt != 8'h00) begin
               res  = rot_w[31:0];
               cout = rot_w[31];
            end
         end
         iasc_pkg::SHK_ROT_EXT: begin
            res  = {cin, val[31:1]};
            cout = val[0];
         end
         default: begin
            res  = val;
            cout = cin;
         end
      endcase
   end

endmodule

// [rtl/iasc_lzc.sv]
`timescale 1ns/1ps
module iasc_lzc (
   input  wire logic [31:0] val,
   output logic      [5:0]  count
);
   // Scanning upward lets the highest set bit have the last word.
   always_comb begin
      count = iasc_pkg::LZC_ALL_ZERO;
      for (int i = 0; i < 32; i++) begin
         if (val[i]) begin
            count = 6'(31 - i);
         end
      end
   end

endmodule

// [rtl/iasc_alu.sv]
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Add gives first operand plus second operand or zero-extended 12-bit immediate.
// - Add with carry sums both operands and carry flag in one addition.
// - Subtract gives first operand minus second operand or 12-bit immediate.
// - Subtract with carry lowers the difference by one when carry is clear.
// - Reverse subtract gives second operand minus first operand.
// - With no destination selected, arithmetic writes back into first operand register.
// - Arithmetic updates N, Z, C, V only when flag setting is selected.
// - Program counter as first operand has its two low bits forced to zero.
// - Add to program counter branches to the sum with bit 0 cleared.
// - AND, OR and exclusive OR combine both operands bit by bit.
// - Bit clear ANDs first operand with complement of second operand.
// - Or-not ORs first operand with complement of second operand.
// - Flag-setting logical operations update N and Z, leave V untouched.
// - Register shift counts use only the low byte, 0 to 255.
// - Immediate counts: arithmetic/logical right 1-32, left 0-31, rotate 1-31.
// - Rotate right extend moves the source right by exactly one bit.
// - Flag-setting shifts set N, Z and carry to last bit out, count zero keeps carry.
// - Leading zero count gives zeros above top set bit, 32 for zero.
// - Leading zero count never changes any flag.
module iasc_alu #(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o
);
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_chk
      $error("iasc_alu: ADDR_W must lie between 5 and 32");
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // State.
   logic [31:0]          opnd1_q;
   logic [31:0]          src_q;
   logic [31:0]          shamt_q;
   logic [31:0]          pc_q;
   logic [31:0]          result_q;
   logic [3:0]           flags_q;
   logic                 illegal_q;
   logic                 branch_q;
   logic                 ack_q;
   logic [31:0]          rdat_q;
   logic [31:0]          rdat_d;
   logic                 req;
   logic                 wr;
   logic                 exec;
   logic                 exec_ok;
   logic                 legal;
   iasc_pkg::iasc_op_t   op;
   logic                 setf;
   logic                 use_imm;
   logic                 pc_src;
   logic                 no_dest;
   logic                 sh_imm;
   logic [5:0]           sh_n;
   logic [31:0]          a;
   logic [31:0]          b;
   logic [31:0]          x;
   logic [31:0]          y;
   logic                 cin;
   logic [32:0]          sum;
   logic                 ovf;
   logic                 is_arith;
   logic                 is_logic;
   logic                 is_shift;
   logic [7:0]           sh_amt;
   iasc_pkg::iasc_shk_t  sh_kind;
   logic [31:0]          sh_res;
   logic                 sh_cout;
   logic [5:0]           lzc;
   logic [31:0]          res_d;
   logic [3:0]           flags_d;
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return m;
   endfunction
   function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [7:0] off);
      return adr == ADDR_W'(off);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus decode and control word fields. Writing the control word starts the operation.
   assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr      = req & wb_we_i;
   assign exec    = wr & hit(wb_adr_i, iasc_pkg::OFF_CTRL);
   assign op      = iasc_pkg::iasc_op_t'(wb_dat_i[iasc_pkg::CTRL_OP_LSB +: iasc_pkg::CTRL_OP_W]);
   assign setf    = wb_dat_i[iasc_pkg::CTRL_SETF_BIT];
   assign use_imm = wb_dat_i[iasc_pkg::CTRL_IMM_BIT];
   assign pc_src  = wb_dat_i[iasc_pkg::CTRL_PC_BIT];
   assign no_dest = wb_dat_i[iasc_pkg::CTRL_NODST_BIT];
   assign sh_imm  = wb_dat_i[iasc_pkg::CTRL_SHIMM_BIT];
   assign sh_n    = wb_dat_i[iasc_pkg::CTRL_SHN_LSB +: iasc_pkg::CTRL_SHN_W];
   assign a = pc_src ? {pc_q[31:2], 2'b00} : opnd1_q;
   assign b = use_imm ? {20'h0_0000, wb_dat_i[iasc_pkg::CTRL_IMM_LSB +: iasc_pkg::IMM_FIELD_W]}
                      : src_q;
   assign sh_amt = sh_imm ? {2'b00, sh_n} : shamt_q[7:0];
   // Out-of-range immediate counts are refused whole: no result, no flags.
   always_comb begin
      legal = wb_dat_i[iasc_pkg::CTRL_OP_LSB +: iasc_pkg::CTRL_OP_W] < iasc_pkg::OP_COUNT;
      if (sh_imm) begin
         unique case (op)
            iasc_pkg::OP_ASHR, iasc_pkg::OP_SHR:
               legal = legal && sh_n >= iasc_pkg::SH_IMM_MIN
                       && sh_n <= iasc_pkg::SH_IMM_MAX_RIGHT;
            iasc_pkg::OP_SHL:
               legal = legal && sh_n <= iasc_pkg::SH_IMM_MAX_SHL;
            iasc_pkg::OP_ROT:
               legal = legal && sh_n >= iasc_pkg::SH_IMM_MIN
                       && sh_n <= iasc_pkg::SH_IMM_MAX_ROT;
            default: legal = legal;
         endcase
      end
   end
   assign exec_ok = exec & legal;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Operand steering for the adder and the shifter.
   always_comb begin
      x        = a;
      y        = b;
      cin      = 1'b0;
      is_arith = 1'b0;
      is_logic = 1'b0;
      is_shift = 1'b0;
      sh_kind  = iasc_pkg::SHK_SHL;
      unique case (op)
         iasc_pkg::OP_ADD: is_arith = 1'b1;
         iasc_pkg::OP_ADD_CARRY: begin
            is_arith = 1'b1;
            cin      = flags_q[iasc_pkg::FLAG_C];
         end
         iasc_pkg::OP_SUB: begin
            is_arith = 1'b1;
            y        = ~b;
            cin      = 1'b1;
         end
         iasc_pkg::OP_SUB_CARRY: begin
            is_arith = 1'b1;
            y        = ~b;
            cin      = flags_q[iasc_pkg::FLAG_C];
         end
         iasc_pkg::OP_REV_SUB: begin
            is_arith = 1'b1;
            x        = b;
            y        = ~a;
            cin      = 1'b1;
         end
         iasc_pkg::OP_ADD_PC_BRANCH: begin
            x = pc_q;
            y = src_q;
         end
         iasc_pkg::OP_AND, iasc_pkg::OP_OR, iasc_pkg::OP_XOR,
         iasc_pkg::OP_BIT_CLEAR, iasc_pkg::OP_OR_NOT: is_logic = 1'b1;
         iasc_pkg::OP_ASHR: begin
            is_shift = 1'b1;
            sh_kind  = iasc_pkg::SHK_ASHR;
         end
         iasc_pkg::OP_SHL: is_shift = 1'b1;
         iasc_pkg::OP_SHR: begin
            is_shift = 1'b1;
            sh_kind  = iasc_pkg::SHK_SHR;
         end
         iasc_pkg::OP_ROT: begin
            is_shift = 1'b1;
            sh_kind  = iasc_pkg::SHK_ROT;
         end
         iasc_pkg::OP_ROT_EXT: begin
            is_shift = 1'b1;
            sh_kind  = iasc_pkg::SHK_ROT_EXT;
         end
         default: x = a;
      endcase
   end
   assign sum = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};
   assign ovf = (x[31] == y[31]) && (sum[31] != x[31]);
   iasc_shifter u_shifter (
      .val  (src_q),
      .amt  (sh_amt),
      .kind (sh_kind),
      .cin  (flags_q[iasc_pkg::FLAG_C]),
      .res  (sh_res),
      .cout (sh_cout)
   );
   iasc_lzc u_lzc (
      .val   (src_q),
      .count (lzc)
   );
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Result and flag selection.
   always_comb begin
      unique case (op)
         iasc_pkg::OP_AND:          res_d = a & b;
         iasc_pkg::OP_OR:           res_d = a | b;
         iasc_pkg::OP_XOR:          res_d = a ^ b;
         iasc_pkg::OP_BIT_CLEAR:    res_d = a & ~b;
         iasc_pkg::OP_OR_NOT:       res_d = a | ~b;
         iasc_pkg::OP_LZC:          res_d = {26'h000_0000, lzc};
         iasc_pkg::OP_ADD_PC_BRANCH: res_d = {sum[31:1], 1'b0};
         default:                   res_d = is_shift ? sh_res : sum[31:0];
      endcase
   end
   // The second-operand shifter is outside this block, so logical ops keep carry.
   always_comb begin
      flags_d = flags_q;
      if (setf && (is_arith || is_logic || is_shift)) begin
         flags_d[iasc_pkg::FLAG_N] = res_d[31];
         flags_d[iasc_pkg::FLAG_Z] = (res_d == 32'h0000_0000);
         if (is_arith) begin
            flags_d[iasc_pkg::FLAG_C] = sum[32];
            flags_d[iasc_pkg::FLAG_V] = ovf;
         end
         if (is_shift && (sh_amt != 8'h00 || op == iasc_pkg::OP_ROT_EXT)) begin
            flags_d[iasc_pkg::FLAG_C] = sh_cout;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers.
   always_ff @(posedge clk) begin
      if (srst) begin
         opnd1_q <= iasc_pkg::RST_WORD;
      end else if (wr && hit(wb_adr_i, iasc_pkg::OFF_OPND1)) begin
         opnd1_q <= merge(opnd1_q, wb_dat_i, wb_sel_i);
      end else if (exec_ok && is_arith && no_dest) begin
         opnd1_q <= res_d;
      end
   end
   // The source register is written by the bus only, never by an operation.
   always_ff @(posedge clk) begin
      if (srst) begin
         src_q <= iasc_pkg::RST_WORD;
      end else if (wr && hit(wb_adr_i, iasc_pkg::OFF_SRC)) begin
         src_q <= merge(src_q, wb_dat_i, wb_sel_i);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         shamt_q <= iasc_pkg::RST_WORD;
      end else if (wr && hit(wb_adr_i, iasc_pkg::OFF_SHAMT)) begin
         shamt_q <= merge(shamt_q, wb_dat_i, wb_sel_i);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pc_q <= iasc_pkg::RST_WORD;
      end else if (wr && hit(wb_adr_i, iasc_pkg::OFF_PC)) begin
         pc_q <= merge(pc_q, wb_dat_i, wb_sel_i);
      end else if (exec_ok && op == iasc_pkg::OP_ADD_PC_BRANCH) begin
         pc_q <= res_d;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         result_q <= iasc_pkg::RST_WORD;
      end else if (exec_ok) begin
         result_q <= res_d;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         flags_q <= iasc_pkg::RST_FLAGS;
      end else if (wr && hit(wb_adr_i, iasc_pkg::OFF_FLAGS) && wb_sel_i[0]) begin
         flags_q <= wb_dat_i[3:0];
      end else if (exec_ok) begin
         flags_q <= flags_d;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         illegal_q <= 1'b0;
         branch_q  <= 1'b0;
      end else if (exec) begin
         illegal_q <= ~legal;
         branch_q  <= legal && op == iasc_pkg::OP_ADD_PC_BRANCH;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait state, unmapped reads return zero, unmapped writes are dropped.
   always_comb begin
      rdat_d = 32'h0000_0000;
      if (hit(wb_adr_i, iasc_pkg::OFF_OPND1))  rdat_d = opnd1_q;
      if (hit(wb_adr_i, iasc_pkg::OFF_SRC))    rdat_d = src_q;
      if (hit(wb_adr_i, iasc_pkg::OFF_SHAMT))  rdat_d = shamt_q;
      if (hit(wb_adr_i, iasc_pkg::OFF_PC))     rdat_d = pc_q;
      if (hit(wb_adr_i, iasc_pkg::OFF_RESULT)) rdat_d = result_q;
      if (hit(wb_adr_i, iasc_pkg::OFF_FLAGS))  rdat_d = {28'h000_0000, flags_q};
      if (hit(wb_adr_i, iasc_pkg::OFF_STATUS)) rdat_d = {30'h0000_0000, branch_q, illegal_q};
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         rdat_q <= iasc_pkg::RST_WORD;
      end else if (req && !wb_we_i) begin
         rdat_q <= rdat_d;
      end
   end
   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   bus_ack_pulse_a: assert property (ack_q |=> !ack_q)
      else $error("ack held longer than one cycle");
   bus_answer_a: assert property (req |=> ack_q)
      else $error("request not answered in the next cycle");
   flags_hold_a: assert property (exec && !setf |=> $stable(flags_q))
      else $error("flags changed without flag setting");
   lzc_flags_a: assert property (exec && op == iasc_pkg::OP_LZC |=> $stable(flags_q))
      else $error("leading zero count changed flags");
   lzc_zero_a: assert property (exec && op == iasc_pkg::OP_LZC && src_q == 32'h0000_0000
                                |=> result_q == 32'h0000_0020)
      else $error("leading zero count of zero is not 32");
   nz_result_a: assert property (exec_ok && setf && (is_arith || is_logic || is_shift)
                                 |=> flags_q[iasc_pkg::FLAG_N] == result_q[31]
                                     && flags_q[iasc_pkg::FLAG_Z] == (result_q == 32'h0))
      else $error("N or Z does not follow the result");
   logic_v_a: assert property (exec_ok && is_logic |=> $stable(flags_q[iasc_pkg::FLAG_V]))
      else $error("logical operation touched overflow");
   src_keep_a: assert property (exec && is_shift |=> $stable(src_q))
      else $error("shift modified its source");
   branch_even_a: assert property (exec_ok && op == iasc_pkg::OP_ADD_PC_BRANCH
                                   |=> pc_q[0] == 1'b0 && branch_q)
      else $error("branch target keeps bit 0");
   pc_base_a: assert property (exec_ok && op == iasc_pkg::OP_ADD && pc_src && !use_imm
                               |=> result_q == ({$past(pc_q[31:2]), 2'b00} + $past(src_q)))
      else $error("program counter base not word aligned");
   rot_ext_a: assert property (exec_ok && op == iasc_pkg::OP_ROT_EXT
                               |=> result_q == {$past(flags_q[iasc_pkg::FLAG_C]),
                                                $past(src_q[31:1])})
      else $error("rotate extend result wrong");
   shift_zero_a: assert property (exec_ok && is_shift && op != iasc_pkg::OP_ROT_EXT
                                  && sh_amt == 8'h00
                                  |=> $stable(flags_q[iasc_pkg::FLAG_C]))
      else $error("zero count shift changed carry");
   imm_refuse_a: assert property (exec && !legal |=> illegal_q && $stable(result_q))
      else $error("illegal count not refused");

   add_flags_c: cover property (exec_ok && op == iasc_pkg::OP_ADD && setf);
   sub_carry_c: cover property (exec_ok && op == iasc_pkg::OP_SUB_CARRY);
   lzc_run_c:   cover property (exec_ok && op == iasc_pkg::OP_LZC);
   branch_c:    cover property (exec_ok && op == iasc_pkg::OP_ADD_PC_BRANCH);

endmodule

// [bench/iasc_wb_host.sv]
`timescale 1ns/1ps
// Master side: issues one classic bus cycle at a time and waits for the answer.
module iasc_wb_host (
   input  wire logic        clk,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dat,
   input  wire logic        ack,
   input  wire logic [31:0] din
);
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we  = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0;
   end

   // The wait has no limit of its own; the bench timeout cuts a hang short.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = din;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      // Released data lines must not keep looking valid.
      dat <= ~d;
   endtask
endmodule

// [bench/integer_alu_shift_clz_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
   $display("BAD %0t %h %h", $time, (a), (e)); end end
module integer_alu_shift_clz_tb_top;
   localparam logic [7:0]  R_OP1 = iasc_pkg::OFF_OPND1;
   localparam logic [7:0]  R_SRC = iasc_pkg::OFF_SRC;
   localparam logic [7:0]  R_SH  = iasc_pkg::OFF_SHAMT;
   localparam logic [7:0]  R_PC  = iasc_pkg::OFF_PC;
   localparam logic [7:0]  R_CT  = iasc_pkg::OFF_CTRL;
   localparam logic [7:0]  R_RES = iasc_pkg::OFF_RESULT;
   localparam logic [7:0]  R_FL  = iasc_pkg::OFF_FLAGS;
   localparam logic [7:0]  R_ST  = iasc_pkg::OFF_STATUS;
   localparam logic [31:0] SF    = 32'h1 << iasc_pkg::CTRL_SETF_BIT;
   localparam logic [31:0] IM    = 32'h1 << iasc_pkg::CTRL_IMM_BIT;
   localparam logic [31:0] PCB   = 32'h1 << iasc_pkg::CTRL_PC_BIT;
   localparam logic [31:0] ND    = 32'h1 << iasc_pkg::CTRL_NODST_BIT;
   localparam logic [31:0] SI    = 32'h1 << iasc_pkg::CTRL_SHIMM_BIT;

   logic        clk;
   logic        srst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc_n = 0;
   logic [4:0]  lop [5];
   logic [31:0] lexp [5];

   iasc_alu #(.ADDR_W(8)) dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack));
   iasc_wb_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
      .dat(wdat), .ack(ack), .din(rdat));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] c(input logic [4:0] o, input logic [31:0] x);
      return {27'h0, o} | x;
   endfunction
   function automatic logic [31:0] sn(input logic [5:0] n);
      return SI | ({26'h0, n} << iasc_pkg::CTRL_SHN_LSB);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      host.xfer(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   task automatic run(input logic [31:0] a, input logic [31:0] b, input logic [31:0] k);
      wr(R_OP1, a);
      wr(R_SRC, b);
      wr(R_CT, k);
   endtask
   task automatic test_done;
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // About 110 bus cycles of three clocks each are expected; the ceiling leaves margin.
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 2000) begin
         err_count++;
         test_done();
      end
   end

   initial begin
      lop = '{iasc_pkg::OP_AND, iasc_pkg::OP_OR, iasc_pkg::OP_XOR, iasc_pkg::OP_BIT_CLEAR,
              iasc_pkg::OP_OR_NOT};
      lexp = '{32'hF000_0034, 32'hFFF0_12FF, 32'h0FF0_12CB, 32'h00F0_1200, 32'hF0FF_FF34};
      srst = 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(R_RES, 32'h0);
      rd(R_FL, 32'h0);
      rd(8'h20, 32'h0);
      run(32'h7FFF_FFFF, 32'h1, c(iasc_pkg::OP_ADD, SF));
      rd(R_RES, 32'h8000_0000);
      rd(R_FL, 32'h9);
      run(32'h1, 32'h1, c(iasc_pkg::OP_ADD, 32'h0));
      rd(R_FL, 32'h9);
      run(32'h10, 32'h0, c(iasc_pkg::OP_ADD, IM | 32'h0FFF_0000));
      rd(R_RES, 32'h100F);
      wr(R_FL, 32'h0);
      run(32'h5, 32'h3, c(iasc_pkg::OP_SUB_CARRY, SF));
      rd(R_RES, 32'h1);
      run(32'h5, 32'h3, c(iasc_pkg::OP_ADD_CARRY, 32'h0));
      rd(R_RES, 32'h9);
      run(32'h5, 32'h3, c(iasc_pkg::OP_REV_SUB, SF));
      rd(R_RES, 32'hFFFF_FFFE);
      rd(R_FL, 32'h8);
      run(32'h5, 32'h3, c(iasc_pkg::OP_SUB, ND));
      rd(R_OP1, 32'h2);
      wr(R_PC, 32'h1003);
      wr(R_CT, c(iasc_pkg::OP_ADD, PCB | IM | 32'h0001_0000));
      rd(R_RES, 32'h1001);
      wr(R_SRC, 32'h11);
      wr(R_CT, c(iasc_pkg::OP_ADD, PCB));
      rd(R_RES, 32'h1011);
      wr(R_PC, 32'h1000);
      wr(R_CT, c(iasc_pkg::OP_ADD_PC_BRANCH, 32'h0));
      rd(R_PC, 32'h1010);
      for (int i = 0; i < 5; i++) begin
         run(32'hF0F0_1234, 32'hFF00_00FF, c(lop[i], 32'h0));
         rd(R_RES, lexp[i]);
      end
      wr(R_FL, 32'h1);
      run(32'hF0, 32'hF0, c(iasc_pkg::OP_BIT_CLEAR, SF));
      rd(R_FL, 32'h5);
      wr(R_FL, 32'h0);
      run(32'h0, 32'h8000_0001, c(iasc_pkg::OP_SHL, SF | sn(6'h01)));
      rd(R_RES, 32'h2);
      rd(R_FL, 32'h2);
      rd(R_SRC, 32'h8000_0001);
      wr(R_SH, 32'h104);
      run(32'h0, 32'h8000_0001, c(iasc_pkg::OP_SHR, 32'h0));
      rd(R_RES, 32'h0800_0000);
      run(32'h0, 32'h8000_0001, c(iasc_pkg::OP_ASHR, sn(6'h20)));
      rd(R_RES, 32'hFFFF_FFFF);
      run(32'h0, 32'h1, c(iasc_pkg::OP_ROT, sn(6'h20)));
      rd(R_ST, 32'h1);
      wr(R_SH, 32'h100);
      run(32'h0, 32'h1, c(iasc_pkg::OP_SHL, SF));
      rd(R_FL, 32'h2);
      run(32'h0, 32'h8000_0001, c(iasc_pkg::OP_ROT_EXT, SF));
      rd(R_RES, 32'hC000_0000);
      rd(R_FL, 32'hA);
      run(32'h0, 32'h0, c(iasc_pkg::OP_LZC, SF));
      rd(R_RES, 32'h20);
      rd(R_FL, 32'hA);
      run(32'h0, 32'h0001_0000, c(iasc_pkg::OP_LZC, 32'h0));
      rd(R_RES, 32'hF);
      wr(R_CT, 32'h0000_001F);
      rd(R_ST, 32'h1);
      rd(R_RES, 32'hF);
      rd(R_CT, 32'h0);
      test_done();
   end
endmodule
